// ==== src/cfb_flag_bank_reg.sv ====
// CPU flag and bank register with masked instruction writes
`timescale 1ns/100ps
`include "cfb_consts.svh"
//
// Behaviour
// - Flag-affecting writes to this register keep computed zero/digit-carry/carry, not written data.
// - Instruction writes never change time-out or power-down bits.
// - Clear-file here zeroes bank bits, sets zero, keeps the other flags.
// - Two direct bank bits pick one 128-byte bank of four.
// - Indirect bank bit picks low or high 256-byte bank pair.
// - Time-out flag high after power-up, clear-watchdog or sleep; low on watchdog time-out.
// - Power-down flag high after power-up; low when sleep executes.
// - Zero flag set when result is zero, cleared otherwise.
// - Digit carry is carry out of bit three; inverted borrow on subtract.
// - Carry is carry out of bit seven; inverted borrow on subtract.
// - Subtraction adds the two's complement of the second operand.
// - Rotates load carry with the bit shifted out.
// - Power-on: bank bits zero, time-out and power-down one, flags zero.
// - Register accepted as destination of any instruction, with masking.
// - Other resets clear bank bits, keep arithmetic flags; master clear keeps reset flags.
module cfb_flag_bank_reg
(
	input wire logic core_clk, // Core instruction clock
	input wire logic rst_n, // Power-on reset, active low
	input wire logic softReset, // Master clear or watchdog reset pulse
	input wire cfb_pkg::cfb_alureq_t aluReq, // ALU operation this cycle
	input wire cfb_pkg::cfb_wr_t wrReq, // Instruction write aimed here
	input wire logic clearWatchdogOp, // Clear-watchdog instruction executed
	input wire logic sleepOp, // Sleep instruction executed
	input wire logic watchdogTimeout, // Watchdog time-out event
	output logic [7:0] statusValue, // Register contents
	output logic [7:0] aluResult, // ALU result for the data path
	input wire logic [6:0] directOffset, // Direct address low bits
	input wire logic [7:0] indirectPointer, // Indirect pointer value
	output logic [8:0] directAddr, // Banked direct address
	output logic [8:0] indirectAddr // Banked indirect address
);
	logic [7:0] status_reg;
	logic [7:0] status_next;
	logic [8:0] direct_reg;
	logic [8:0] indirect_reg;
	cfb_pkg::cfb_alures_t aluRes;
	logic [7:0] aluResult_reg;

	// ----------------------------------------
	// Arithmetic unit
	// ----------------------------------------
	cfb_flag_alu u_alu
	(
		.req(aluReq),
		.carryIn(status_reg[`CFB_BIT_CARRY]),
		.res(aluRes)
	);

	// Bank base address from two select bits
	function automatic logic [8:0] bankBase(input logic [1:0] sel);
		bankBase = 9'(sel) * `CFB_BANK_BYTES;
	endfunction

	// ----------------------------------------
	// Next register value
	// ----------------------------------------
	// Writes pass the bank and arithmetic fields, then flags override
	always_comb
	begin
		status_next = status_reg;
		if (wrReq.wrEn)
		begin
			status_next = (status_reg & `CFB_RESET_MASK)
				| (wrReq.wrData & ~`CFB_RESET_MASK);
		end
		if (wrReq.clearFile)
		begin
			status_next = status_reg & ~`CFB_BANK_MASK;
			status_next[`CFB_BIT_ZERO] = 1'b1;
		end
		if (aluRes.setsZero)
		begin
			status_next[`CFB_BIT_ZERO] = aluRes.zero;
		end
		if (aluRes.setsCarries)
		begin
			status_next[`CFB_BIT_CARRY] = aluRes.carry;
			if (aluReq.op == cfb_pkg::CFB_OP_ADD || aluReq.op == cfb_pkg::CFB_OP_SUB)
			begin
				status_next[`CFB_BIT_DCARRY] = aluRes.dcarry;
			end
		end
		if (clearWatchdogOp || sleepOp)
		begin
			status_next[`CFB_BIT_TIMEOUT] = 1'b1;
		end
		if (sleepOp)
		begin
			status_next[`CFB_BIT_PWRDN] = 1'b0;
		end
		if (watchdogTimeout)
		begin
			status_next[`CFB_BIT_TIMEOUT] = 1'b0;
		end
		if (softReset)
		begin
			status_next = status_reg & ~`CFB_BANK_MASK;
			if (watchdogTimeout)
			begin
				status_next[`CFB_BIT_TIMEOUT] = 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Register state
	// ----------------------------------------
	// Power-on value; arithmetic flags come up zero here
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			status_reg <= `CFB_POR_VALUE;
		end
		else
		begin
			status_reg <= status_next;
		end
	end

	// Registered ALU result
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			aluResult_reg <= 8'h00;
		end
		else if (aluReq.valid)
		begin
			aluResult_reg <= aluRes.result;
		end
	end

	// ----------------------------------------
	// Address formation
	// ----------------------------------------
	// Banked addresses from the register's select bits
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			direct_reg <= 9'h000;
			indirect_reg <= 9'h000;
		end
		else
		begin
			direct_reg <= bankBase(status_next[`CFB_BIT_BANK_HI:`CFB_BIT_BANK_LO])
				| {2'b00, directOffset};
			indirect_reg <= {status_next[`CFB_BIT_IRP_SEL], indirectPointer};
		end
	end

	assign statusValue = status_reg;
	assign aluResult = aluResult_reg;
	assign directAddr = direct_reg;
	assign indirectAddr = indirect_reg;
endmodule // cfb_flag_bank_reg

// ==== inc/cfb_consts.svh ====
// Constants for the CPU flag and bank register block
`ifndef CFB_CONSTS_SVH
`define CFB_CONSTS_SVH
`define CFB_BIT_IRP_SEL 7
`define CFB_BIT_BANK_HI 6
`define CFB_BIT_BANK_LO 5
`define CFB_BIT_TIMEOUT 4
`define CFB_BIT_PWRDN 3
`define CFB_BIT_ZERO 2
`define CFB_BIT_DCARRY 1
`define CFB_BIT_CARRY 0
`define CFB_ARITH_MASK 8'h07
`define CFB_RESET_MASK 8'h18
`define CFB_BANK_MASK 8'he0
`define CFB_POR_VALUE 8'h18
`define CFB_BANK_BYTES 9'h080
`define CFB_BANK_OFS_W 7
`define CFB_PAIR_OFS_W 8
`define CFB_NIBBLE_W 4
`endif

// ==== inc/cfb_pkg.sv ====
// Types shared by the CPU flag and bank register block
package cfb_pkg;
	typedef enum logic [2:0] {
		CFB_OP_NONE = 3'h0,
		CFB_OP_ADD = 3'h1,
		CFB_OP_SUB = 3'h2,
		CFB_OP_LOGIC = 3'h3,
		CFB_OP_ROT_R = 3'h4,
		CFB_OP_ROT_L = 3'h5
	} cfb_aluop_t;
	typedef struct packed {
		logic valid;
		cfb_aluop_t op;
		logic [7:0] opA;
		logic [7:0] opB;
	} cfb_alureq_t;
	typedef struct packed {
		logic [7:0] result;
		logic zero;
		logic dcarry;
		logic carry;
		logic setsZero;
		logic setsCarries;
	} cfb_alures_t;
	typedef struct packed {
		logic wrEn;
		logic [7:0] wrData;
		logic clearFile;
	} cfb_wr_t;
endpackage

// ==== src/cfb_flag_alu.sv ====
// Flag-producing arithmetic unit for the CPU flag and bank register
`timescale 1ns/100ps
`include "cfb_consts.svh"
module cfb_flag_alu
(
	input wire cfb_pkg::cfb_alureq_t req, // Operation and operands
	input wire logic carryIn, // Current carry for rotates
	output cfb_pkg::cfb_alures_t res // Result with flags
);
	logic [8:0] sum;
	logic [4:0] lowSum;
	logic [7:0] addend;
	logic addCin;

	// Subtract by adding the two's complement of the second operand
	always_comb
	begin
		addend = (req.op == cfb_pkg::CFB_OP_SUB) ? ~req.opB : req.opB;
		addCin = (req.op == cfb_pkg::CFB_OP_SUB);
		sum = {1'b0, req.opA} + {1'b0, addend} + {8'h00, addCin};
		lowSum = {1'b0, req.opA[`CFB_NIBBLE_W-1:0]} + {1'b0, addend[`CFB_NIBBLE_W-1:0]}
			+ {4'h0, addCin};
	end

	// Result and flag formation per operation
	always_comb
	begin
		res = '0;
		unique case (req.op)
			cfb_pkg::CFB_OP_ADD, cfb_pkg::CFB_OP_SUB:
			begin
				res.result = sum[7:0];
				res.carry = sum[8];
				res.dcarry = lowSum[`CFB_NIBBLE_W];
				res.setsZero = 1'b1;
				res.setsCarries = 1'b1;
			end
			cfb_pkg::CFB_OP_LOGIC:
			begin
				res.result = req.opA;
				res.setsZero = 1'b1;
			end
			cfb_pkg::CFB_OP_ROT_R:
			begin
				res.result = {carryIn, req.opA[7:1]};
				res.carry = req.opA[0];
			end
			cfb_pkg::CFB_OP_ROT_L:
			begin
				res.result = {req.opA[6:0], carryIn};
				res.carry = req.opA[7];
			end
			cfb_pkg::CFB_OP_NONE:
			begin
				res.result = req.opA;
			end
			default:
			begin
				res.result = req.opA;
			end
		endcase
		res.zero = (res.result == 8'h00);
		res.setsCarries = res.setsCarries | (req.op == cfb_pkg::CFB_OP_ROT_R)
			| (req.op == cfb_pkg::CFB_OP_ROT_L);
		res.setsZero = res.setsZero & req.valid;
		res.setsCarries = res.setsCarries & req.valid;
	end
endmodule // cfb_flag_alu

// ==== verif/cfb_flag_bank_reg_chk.sv ====
// Assertion checker for the flag and bank register
`timescale 1ns/100ps
module cfb_flag_bank_reg_chk
(
	input wire logic core_clk, // Clock
	input wire logic rst_n, // Reset
	input wire logic softReset, // Soft reset
	input wire cfb_pkg::cfb_alureq_t aluReq, // ALU op
	input wire cfb_pkg::cfb_wr_t wrReq, // Write
	input wire logic clearWatchdogOp, // Clear watchdog
	input wire logic sleepOp, // Sleep
	input wire logic watchdogTimeout, // Time-out
	input wire logic [7:0] statusValue, // Register
	input wire logic [7:0] aluResult, // Result
	input wire logic [6:0] directOffset, // Offset
	input wire logic [8:0] directAddr // Address
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	ro_bits_a:
	assert property (wrReq.wrEn && !clearWatchdogOp && !sleepOp && !watchdogTimeout
		|=> $stable(statusValue[4:3])) else $error("reset bits written");
	wdt_low_a:
	assert property (watchdogTimeout |=> !statusValue[4]) else $error("time-out bit high");
	sleep_pd_a:
	assert property (sleepOp && !watchdogTimeout && !softReset |=> statusValue[4:3] == 2'b10)
		else $error("sleep bits wrong");
	clear_file_a:
	assert property (wrReq.clearFile && !aluReq.valid && !softReset
		|=> statusValue[7:5] == 3'h0 && statusValue[2]) else $error("clear wrong");
	zero_flag_a:
	assert property (aluReq.valid && !softReset && aluReq.op inside {3'h1, 3'h2, 3'h3}
		|=> statusValue[2] == (aluResult == 8'h00)) else $error("zero wrong");
	add_carry_a:
	assert property (aluReq.valid && !softReset && aluReq.op == 3'h1 |=> statusValue[0]
		== ({1'b0, $past(aluReq.opA)} + $past(aluReq.opB) > 9'h0ff)) else $error("carry");
	sub_borrow_a:
	assert property (aluReq.valid && !softReset && aluReq.op == 3'h2 |=> statusValue[0]
		== ($past(aluReq.opA) >= $past(aluReq.opB))) else $error("borrow wrong");
	rot_carry_a:
	assert property (aluReq.valid && !softReset && aluReq.op == 3'h4
		|=> statusValue[0] == $past(aluReq.opA[0])) else $error("rotate carry");
	direct_addr_a:
	assert property (1'b1 |=> directAddr == {statusValue[6:5], $past(directOffset)})
		else $error("direct address");
endmodule // cfb_flag_bank_reg_chk
bind cfb_flag_bank_reg cfb_flag_bank_reg_chk cfb_flag_bank_reg_chk_inst (.core_clk, .rst_n,
	.softReset, .aluReq, .wrReq, .clearWatchdogOp, .sleepOp, .watchdogTimeout,
	.statusValue, .aluResult, .directOffset, .directAddr);

// ==== verif/cfb_cpu_model.sv ====
// Instruction side model issuing ALU requests and register writes
`timescale 1ns/100ps
module cfb_cpu_model
(
	input wire logic [31:0] seedA, // Operand word
	input wire logic [31:0] seedB, // Control word
	output cfb_pkg::cfb_alureq_t aluReq, // ALU request
	output cfb_pkg::cfb_wr_t wrReq // Register write
);
	// Decode random words into one instruction
	always_comb
	begin
		aluReq = '{seedB[0], cfb_pkg::cfb_aluop_t'(seedB[3:1] % 3'h6), seedA[7:0], seedA[15:8]};
		wrReq = '{seedB[4], seedA[23:16] & (seedB[7] ? 8'h3f : 8'hff), seedB[5] & seedB[6]};
	end
endmodule // cfb_cpu_model

// ==== verif/cfb_flag_bank_reg_tb.sv ====
// Self-checking bench for the flag and bank register
`timescale 1ns/100ps
module cfb_flag_bank_reg_tb;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [31:0] seedA = 32'h0;
	logic [31:0] seedB = 32'h27e87417;
	logic [7:0] statusValue, aluResult, s, n, res;
	logic [8:0] directAddr, indirectAddr, expDir, expInd;
	cfb_pkg::cfb_alureq_t aluReq;
	cfb_pkg::cfb_wr_t wrReq;
	int errorCnt = 0;
	int compares = 0;
	int a, b, op, sum, dc;
	bit chkRes, chkInd;
	wire logic softReset = seedB[31:28] == 4'h0;
	wire logic wdtEvt = seedB[27:25] == 3'h0;
	wire logic sleepEvt = seedB[24:22] == 3'h0;
	wire logic clrEvt = seedB[21:19] == 3'h0;
	cfb_cpu_model cfb_cpu_model_inst (.seedA(seedA), .seedB(seedB), .aluReq(aluReq),
		.wrReq(wrReq));
	cfb_flag_bank_reg cfb_flag_bank_reg_inst (.core_clk(core_clk), .rst_n(rst_n),
		.softReset(softReset), .aluReq(aluReq), .wrReq(wrReq), .clearWatchdogOp(clrEvt),
		.sleepOp(sleepEvt), .watchdogTimeout(wdtEvt), .statusValue(statusValue),
		.aluResult(aluResult), .directOffset(seedA[30:24]), .indirectPointer(seedB[15:8]),
		.directAddr(directAddr), .indirectAddr(indirectAddr));
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h0);
	endfunction
	task automatic chk(input logic [8:0] got, input logic [8:0] exp);
		compares++;
		if (got !== exp)
		begin
			errorCnt++;
			$display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wrapUp;
		if (errorCnt == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// Clock
	initial
	begin
		forever #4 core_clk = ~core_clk;
	end
	// Hang guard
	initial
	begin
		#20000;
		errorCnt++;
		wrapUp();
	end
	// Two reset runs of random instructions against the model
	initial
	begin
		for (int k = 0; k < 2; k++)
		begin
			rst_n = 1'b0;
			repeat (20) @(negedge core_clk);
			rst_n = 1'b1;
			#1 chk({1'b0, statusValue}, 9'h018);
			s = 8'h18;
			for (int i = 0; i < 600; i++)
			begin
				seedA = lfsr(seedB);
				seedB = lfsr(seedA);
				#1 n = s;
				if (wrReq.wrEn) n = (s & 8'h18) | (wrReq.wrData & 8'he7);
				if (wrReq.clearFile) n = (s & 8'h1b) | 8'h04;
				a = aluReq.opA;
				b = aluReq.opB;
				op = aluReq.valid ? int'(aluReq.op) : 0;
				sum = op == 1 ? a + b : op == 2 ? a + 256 - b : a;
				dc = op == 1 ? (a & 15) + (b & 15) : (a & 15) + 16 - (b & 15);
				res = op == 4 ? {s[0], aluReq.opA[7:1]} : op == 5 ? {aluReq.opA[6:0], s[0]} : sum[7:0];
				if (op > 0 && op < 4) n[2] = res == 8'h00;
				if (op > 0 && op < 3) n[1:0] = {dc > 15, sum > 255};
				if (op > 3) n[0] = aluReq.opA[op == 4 ? 0 : 7];
				if (clrEvt) n[4] = 1'b1;
				if (sleepEvt) n[4:3] = 2'b10;
				if (wdtEvt) n[4] = 1'b0;
				if (softReset) n = s & 8'h1f;
				if (softReset && wdtEvt) n[4] = 1'b0;
				chkRes = op > 0;
				chkInd = n[7] == s[7];
				expDir = {n[6:5], seedA[30:24]};
				expInd = {n[7], seedB[15:8]};
				s = n;
				@(negedge core_clk);
				chk({1'b0, statusValue}, {1'b0, s});
				chk(directAddr, expDir);
				if (chkInd) chk(indirectAddr, expInd);
				if (chkRes) chk({1'b0, aluResult}, {1'b0, res});
			end
		end
		wrapUp();
	end
endmodule // cfb_flag_bank_reg_tb
